// ==== src/vdms_pkg.sv ====
/*
 * Constants and carrier types for the decoder control and status bank.
 * Assumes a single 100 MHz decoder clock and a two-wire control bus.
 */
package vdms_pkg;

    // Subaddresses
    localparam logic [7:0] ADDR_MISC    = 8'h17;
    localparam logic [7:0] ADDR_GAIN    = 8'h18;
    localparam logic [7:0] ADDR_OFFSET  = 8'h19;
    localparam logic [7:0] ADDR_STAT1   = 8'h1E;
    localparam logic [7:0] ADDR_STAT2   = 8'h1F;

    // Field positions in the miscellaneous register
    localparam int BIT_LINE_CLK_DIS     = 7;
    localparam int BIT_HALF_CLK_DIS     = 6;
    localparam int LAT_HI               = 5;
    localparam int LAT_LO               = 3;
    localparam int BIT_ALT_GATE         = 2;
    localparam int BIT_STOP_MSB         = 1;
    localparam int BIT_START_MSB        = 0;

    // Reset values
    localparam logic [7:0] RST_MISC     = 8'h18;
    localparam logic [7:0] RST_GAIN     = 8'h80;
    localparam logic [7:0] RST_OFFSET   = 8'h80;

    // Search latency encodings
    localparam logic [2:0] LAT_RESERVED = 3'h0;
    localparam logic [2:0] LAT_DEFAULT  = 3'h3;

    // Raw data scaling
    localparam int GAIN_SHIFT           = 7;
    localparam logic [7:0] GAIN_OFF     = 8'h00;
    localparam logic [7:0] OFFSET_MAX   = 8'hFF;
    localparam logic signed [10:0] OFFSET_ZERO = 11'sh080;
    localparam logic signed [10:0] OFFSET_TOP  = 11'sh080;
    localparam logic signed [10:0] SAMPLE_MAX  = 11'sh0FF;

    // Control bus byte length
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        VDMS_IDLE    = 4'b0000,
        VDMS_ADDR    = 4'b0001,
        VDMS_ADDR_AK = 4'b0010,
        VDMS_SUB     = 4'b0011,
        VDMS_SUB_AK  = 4'b0100,
        VDMS_WR      = 4'b0101,
        VDMS_WR_AK   = 4'b0110,
        VDMS_RD      = 4'b0111,
        VDMS_RD_AK   = 4'b1000
    } vdms_bus_state_e;

    // Detector state from the decoder core
    typedef struct packed {
        logic       horiz_locked;
        logic       vert_locked;
        logic       all_loops_locked;
        logic       slow_tc_active;
        logic       gain_at_max;
        logic       gain_at_min;
        logic       white_peak_active;
        logic [1:0] colour_standard;
        logic       interlaced;
        logic       field_60hz;
        logic       stripe_stripe_type_three_flag;
        logic       stripe_any;
        logic       copy_protected;
    } vdms_detect_s;

    // Line timing from the decoder core
    typedef struct packed {
        logic       line_start;
        logic       field_start;
        logic       field_two;
        logic [8:0] line_count;
    } vdms_timing_s;

endpackage

// ==== src/vdms_regs.sv ====
/*
 * Control and status bank of the video decoder with its two-wire slave,
 * vertical gate generator, search loop pacing and raw data scaler.
 * Assumes detector and timing inputs come from logic on mclk_i, while
 * the serial clock and data pins are asynchronous.
 */
// Summary of operation
// (R1) Bits 7/6 low drive clock outputs
// (R2) Search latency in fields, 000 reserved
// (R3) Alternative position: gate one line earlier; code applies it in field two only
// (R4) Gate rises, field identifier toggles at start
// (R5) Gate falls at nine-bit stop line
// (R6) Gain scales raw data, zero is off
// (R7) Offset binary from -128 to +128
// (R8) First status byte, colour standard code
// (R9) Bit 6 high when horizontal unlocked
// (R10) Bit 5 shows slow time constant
// (R11) Bits 4/3 show gain limit top/bottom
// (R12) Bit 2 shows white peak loop
// (R13) Second status byte, bit 4 undefined
// (R14) Bit 7 shows interlaced source
// (R15) Bit 6 low only when both locked
// (R16) Bit 5 shows 60 Hz field rate
// (R17) Bit 3 shows type three stripe
// (R18) Bit 2 shows any colour stripe
// (R19) Bit 1 shows copy protected source
// (R20) Bit 0 ready when all loops locked
// (R21) Status reads side-free, writes ignored
`timescale 1ns/1ps

module vdms_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h21  // Arbitrary value
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe_o,
    input  wire vdms_pkg::vdms_detect_s detect_i,
    input  wire vdms_pkg::vdms_timing_s timing_i,
    input  wire logic [7:0]            gate_start_lsb_i,
    input  wire logic [7:0]            gate_stop_lsb_i,
    input  wire logic [7:0]            raw_data_i,
    input  wire logic                  raw_valid_i,
    output logic                       line_clock_oe_o,
    output logic                       half_line_clock_oe_o,
    output logic [2:0]                 search_loop_latency_o,
    output logic                       search_step_o,
    output logic                       vertical_gate_o,
    output logic                       field_identifier_o,
    output logic [7:0]                 raw_data_o,
    output logic                       raw_valid_o
);

    // Reset release and pin synchronisers
    logic       rst_meta_r;
    logic       rst_n;
    logic [2:0] scl_r;
    logic [2:0] sda_r;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_r <= 3'h7;
            sda_r <= 3'h7;
        end
        else
        begin
            scl_r <= {scl_r[1:0], scl_i};
            sda_r <= {sda_r[1:0], sda_i};
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sda_s;

    assign sda_s     = sda_r[1];
    assign scl_rise  = scl_r[1] & ~scl_r[2];
    assign scl_fall  = ~scl_r[1] & scl_r[2];
    assign bus_start = scl_r[1] & scl_r[2] & ~sda_r[1] & sda_r[2];
    assign bus_stop  = scl_r[1] & scl_r[2] & sda_r[1] & ~sda_r[2];

    // Register file
    logic [7:0] misc_r;
    logic [7:0] gain_r;
    logic [7:0] offset_r;
    logic [7:0] misc_nxt;
    logic [7:0] gain_nxt;
    logic [7:0] offset_nxt;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic       wr_en;
    logic [7:0] sub_r;
    logic [7:0] shift_r;

    // Status bytes sampled live, bit 7 of the first and bit 4 of the second read zero
    assign stat1 = {1'b0,
                    ~detect_i.horiz_locked,               // see (R9)
                    detect_i.slow_tc_active,              // see (R10)
                    detect_i.gain_at_max,                 // see (R11)
                    detect_i.gain_at_min,                 // see (R11)
                    detect_i.white_peak_active,           // see (R12)
                    detect_i.colour_standard};            // see (R8)
    assign stat2 = {detect_i.interlaced,                  // see (R14)
                    ~(detect_i.horiz_locked &
                      detect_i.vert_locked),              // see (R15)
                    detect_i.field_60hz,                  // see (R16)
                    1'b0,                                 // see (R13)
                    detect_i.stripe_stripe_type_three_flag,                // see (R17)
                    detect_i.stripe_any,                  // see (R18)
                    detect_i.copy_protected,              // see (R19)
                    detect_i.all_loops_locked &
                    detect_i.horiz_locked &
                    detect_i.vert_locked};                // see (R20)

    function automatic logic [7:0] read_mux(input logic [7:0] sub);
        logic [7:0] val;
        val = 8'h00;
        unique case (sub)
            vdms_pkg::ADDR_MISC:   val = misc_r;
            vdms_pkg::ADDR_GAIN:   val = gain_r;
            vdms_pkg::ADDR_OFFSET: val = offset_r;
            vdms_pkg::ADDR_STAT1:  val = stat1;
            vdms_pkg::ADDR_STAT2:  val = stat2;
            default:               val = 8'h00;
        endcase
        return val;
    endfunction

    always_comb
    begin
        misc_nxt   = misc_r;
        gain_nxt   = gain_r;
        offset_nxt = offset_r;
        if (wr_en)
        begin
            // Status subaddresses fall through untouched, see (R21)
            unique case (sub_r)
                vdms_pkg::ADDR_MISC:   misc_nxt   = shift_r;
                vdms_pkg::ADDR_GAIN:   gain_nxt   = shift_r;
                vdms_pkg::ADDR_OFFSET: offset_nxt = shift_r;
                default:               misc_nxt   = misc_r;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            misc_r   <= vdms_pkg::RST_MISC;
            gain_r   <= vdms_pkg::RST_GAIN;
            offset_r <= vdms_pkg::RST_OFFSET;
        end
        else
        begin
            misc_r   <= misc_nxt;
            gain_r   <= gain_nxt;
            offset_r <= offset_nxt;
        end
    end

    // Two-wire slave
    vdms_pkg::vdms_bus_state_e st_r;
    vdms_pkg::vdms_bus_state_e st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] shift_nxt;
    logic [7:0] sub_nxt;
    logic       rw_r;
    logic       rw_nxt;
    logic       drive_r;
    logic       drive_nxt;
    logic [7:0] rd_byte;

    // Procedural, so a change of any bank byte reaches the read path
    always_comb
    begin
        rd_byte = read_mux(sub_r);
    end

    always_comb
    begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        sub_nxt   = sub_r;
        rw_nxt    = rw_r;
        drive_nxt = drive_r;
        wr_en     = 1'b0;
        if (bus_stop)
        begin
            st_nxt    = vdms_pkg::VDMS_IDLE;
            drive_nxt = 1'b0;
        end
        else if (bus_start)
        begin
            st_nxt    = vdms_pkg::VDMS_ADDR;
            cnt_nxt   = 4'h0;
            drive_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                vdms_pkg::VDMS_IDLE:
                    st_nxt = st_r;
                vdms_pkg::VDMS_ADDR, vdms_pkg::VDMS_SUB, vdms_pkg::VDMS_WR:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt   = cnt_r + 4'h1;
                    end
                    else if (scl_fall && cnt_r == vdms_pkg::BITS_PER_BYTE)
                    begin
                        drive_nxt = 1'b1;
                        if (st_r == vdms_pkg::VDMS_ADDR)
                        begin
                            rw_nxt = shift_r[0];
                            if (shift_r[7:1] == DEV_ADDR)
                                st_nxt = vdms_pkg::VDMS_ADDR_AK;
                            else
                            begin
                                st_nxt    = vdms_pkg::VDMS_IDLE;
                                drive_nxt = 1'b0;
                            end
                        end
                        else if (st_r == vdms_pkg::VDMS_SUB)
                        begin
                            sub_nxt = shift_r;
                            st_nxt  = vdms_pkg::VDMS_SUB_AK;
                        end
                        else
                        begin
                            wr_en   = 1'b1;
                            sub_nxt = sub_r + 8'h01;
                            st_nxt  = vdms_pkg::VDMS_WR_AK;
                        end
                    end
                end
                vdms_pkg::VDMS_ADDR_AK:
                    if (scl_fall)
                    begin
                        cnt_nxt = 4'h0;
                        if (rw_r)
                        begin
                            shift_nxt = rd_byte;
                            drive_nxt = ~rd_byte[7];
                            st_nxt    = vdms_pkg::VDMS_RD;
                        end
                        else
                        begin
                            drive_nxt = 1'b0;
                            st_nxt    = vdms_pkg::VDMS_SUB;
                        end
                    end
                vdms_pkg::VDMS_SUB_AK, vdms_pkg::VDMS_WR_AK:
                    if (scl_fall)
                    begin
                        drive_nxt = 1'b0;
                        cnt_nxt   = 4'h0;
                        st_nxt    = vdms_pkg::VDMS_WR;
                    end
                vdms_pkg::VDMS_RD:
                    if (scl_rise)
                        cnt_nxt = cnt_r + 4'h1;
                    else if (scl_fall)
                    begin
                        if (cnt_r == vdms_pkg::BITS_PER_BYTE)
                        begin
                            drive_nxt = 1'b0;
                            sub_nxt   = sub_r + 8'h01;
                            st_nxt    = vdms_pkg::VDMS_RD_AK;
                        end
                        else
                        begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            drive_nxt = ~shift_r[6];
                        end
                    end
                vdms_pkg::VDMS_RD_AK:
                    if (scl_rise && sda_s)
                        st_nxt = vdms_pkg::VDMS_IDLE;
                    else if (scl_fall)
                    begin
                        // Reads have no side effect on state, see (R21)
                        cnt_nxt   = 4'h0;
                        shift_nxt = rd_byte;
                        drive_nxt = ~rd_byte[7];
                        st_nxt    = vdms_pkg::VDMS_RD;
                    end
                default:
                begin
                    st_nxt    = vdms_pkg::VDMS_IDLE;
                    drive_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r    <= vdms_pkg::VDMS_IDLE;
            cnt_r   <= 4'h0;
            shift_r <= 8'h00;
            sub_r   <= 8'h00;
            rw_r    <= 1'b0;
            drive_r <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            sub_r   <= sub_nxt;
            rw_r    <= rw_nxt;
            drive_r <= drive_nxt;
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = drive_r;

    // Clock output enables
    assign line_clock_oe_o      =
        ~misc_r[vdms_pkg::BIT_LINE_CLK_DIS];                   // see (R1)
    assign half_line_clock_oe_o =
        ~misc_r[vdms_pkg::BIT_HALF_CLK_DIS];                   // see (R1)

    // Search loop pacing, one step each latency fields
    logic [2:0] lat;
    logic [2:0] fld_r;
    logic [2:0] fld_nxt;
    logic       step_nxt;
    logic       step_r;

    assign lat = (misc_r[vdms_pkg::LAT_HI:vdms_pkg::LAT_LO] ==
                  vdms_pkg::LAT_RESERVED) ? vdms_pkg::LAT_DEFAULT
               : misc_r[vdms_pkg::LAT_HI:vdms_pkg::LAT_LO];   // see (R2)

    always_comb
    begin
        fld_nxt  = fld_r;
        step_nxt = 1'b0;
        if (timing_i.field_start)
        begin
            if (fld_r + 3'h1 >= lat)                           // see (R2)
            begin
                fld_nxt  = 3'h0;
                step_nxt = 1'b1;
            end
            else
                fld_nxt = fld_r + 3'h1;
        end
    end

    // Vertical gate and field identifier
    logic [8:0] start_line;
    logic [8:0] stop_line;
    logic [8:0] cmp_line;
    logic       gate_r;
    logic       gate_nxt;
    logic       fid_r;
    logic       fid_nxt;

    assign start_line = {misc_r[vdms_pkg::BIT_START_MSB],
                         gate_start_lsb_i};                    // see (R4)
    assign stop_line  = {misc_r[vdms_pkg::BIT_STOP_MSB],
                         gate_stop_lsb_i};                     // see (R5)
    // Looking one line ahead moves the gate one line earlier
    assign cmp_line   = (misc_r[vdms_pkg::BIT_ALT_GATE] &&
                         timing_i.field_two)
                      ? timing_i.line_count + 9'h001
                      : timing_i.line_count;                   // see (R3)

    always_comb
    begin
        gate_nxt = gate_r;
        fid_nxt  = fid_r;
        if (timing_i.line_start)
        begin
            if (cmp_line == start_line)
            begin
                gate_nxt = 1'b1;                               // see (R4)
                fid_nxt  = ~fid_r;                             // see (R4)
            end
            else if (cmp_line == stop_line)
                gate_nxt = 1'b0;                               // see (R5)
        end
    end

    // Raw data gain and offset
    logic [15:0]       prod;
    logic signed [10:0] scaled;
    logic signed [10:0] offs;
    logic signed [10:0] sum;
    logic [7:0]        raw_nxt;
    logic              rvalid_nxt;
    logic [7:0]        raw_r;
    logic              rvalid_r;

    assign prod   = raw_data_i * gain_r;                       // see (R6)
    assign scaled = signed'({2'b00, prod[15:vdms_pkg::GAIN_SHIFT]});
    assign offs   = (offset_r == vdms_pkg::OFFSET_MAX)
                  ? vdms_pkg::OFFSET_TOP
                  : signed'({3'b000, offset_r}) - vdms_pkg::OFFSET_ZERO;
    assign sum    = scaled + offs;                             // see (R7)

    always_comb
    begin
        rvalid_nxt = raw_valid_i && (gain_r != vdms_pkg::GAIN_OFF); // see (R6)
        if (gain_r == vdms_pkg::GAIN_OFF)
            raw_nxt = 8'h00;
        else if (sum < 0)
            raw_nxt = 8'h00;
        else if (sum > vdms_pkg::SAMPLE_MAX)
            raw_nxt = 8'hFF;
        else
            raw_nxt = sum[7:0];
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fld_r    <= 3'h0;
            step_r   <= 1'b0;
            gate_r   <= 1'b0;
            fid_r    <= 1'b0;
            raw_r    <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            fld_r    <= fld_nxt;
            step_r   <= step_nxt;
            gate_r   <= gate_nxt;
            fid_r    <= fid_nxt;
            raw_r    <= raw_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign search_loop_latency_o = lat;
    assign search_step_o         = step_r;
    assign vertical_gate_o       = gate_r;
    assign field_identifier_o    = fid_r;
    assign raw_data_o            = raw_r;
    assign raw_valid_o           = rvalid_r;

endmodule

// ==== testbench/vdms_regs_chk.sv ====
/*
 * Port assertions for the decoder control bank.
 * Assumes one clock and an async active-low reset; bound below.
 */
`timescale 1ns/1ps
module vdms_regs_chk (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   scl_i,
    input  wire logic                   sda_oe_o,
    input  wire vdms_pkg::vdms_timing_s timing_i,
    input  wire logic                   raw_valid_i,
    input  wire logic                   raw_valid_o,
    input  wire logic [2:0]             search_loop_latency_o,
    input  wire logic                   search_step_o,
    input  wire logic                   vertical_gate_o,
    input  wire logic                   field_identifier_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sda_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data pin moved while clock high");
    lat_valid_a: assert property (search_loop_latency_o != 3'h0)
        else $error("reserved latency on output");
    step_cause_a: assert property (
        search_step_o |-> $past(timing_i.field_start))
        else $error("step without field start");
    gate_rise_a: assert property (
        $rose(vertical_gate_o) |-> $past(timing_i.line_start))
        else $error("gate rose off a line start");
    gate_fall_a: assert property (
        $fell(vertical_gate_o) |-> $past(timing_i.line_start))
        else $error("gate fell off a line start");
    fid_tog_a: assert property (
        $rose(vertical_gate_o) |-> $changed(field_identifier_o))
        else $error("field flag kept at gate start");
    fid_cause_a: assert property (
        $changed(field_identifier_o) |-> $past(timing_i.line_start))
        else $error("field flag moved off a line start");
    raw_lat_a: assert property (
        raw_valid_o |-> $past(raw_valid_i))
        else $error("raw valid without input sample");
endmodule

bind vdms_regs vdms_regs_chk u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
    .sda_oe_o(sda_oe_o), .timing_i(timing_i),
    .raw_valid_i(raw_valid_i), .raw_valid_o(raw_valid_o),
    .search_loop_latency_o(search_loop_latency_o),
    .search_step_o(search_step_o), .vertical_gate_o(vertical_gate_o),
    .field_identifier_o(field_identifier_o)
);

// ==== testbench/vdms_host.sv ====
/*
 * Two-wire control bus host model.
 * Assumes an open-drain data line with a pull-up, built by the bench.
 */
`timescale 1ns/1ps
module vdms_host (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick();
        repeat (10) @(negedge clk_i);
    endtask
    // Start or repeated start
    task automatic start();
        sda_low_o = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        sda_low_o = 1'b1;
        tick();
        scl_o = 1'b0;
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        sda_low_o = 1'b0;
        tick();
    endtask
    // Eight data bits then the acknowledge bit, MSB first
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low_o = ~tx[i];
            tick();
            scl_o = 1'b1;
            tick();
            rx[i] = sda_i;
            scl_o = 1'b0;
        end
    endtask
endmodule

// ==== testbench/vdms_regs_tb_top.sv ====
/*
 * Self-checking bench for the decoder control bank.
 * Assumes the host model and checker are compiled before it.
 */
`timescale 1ns/1ps
module vdms_regs_tb_top;
    logic                   mclk, rst_n, scl, sda_low, sda_o, sda_oe;
    logic                   raw_v, lclk_oe, hclk_oe, step, gate, field_identifier;
    logic                   raw_vo;
    logic [2:0]             lat;
    logic [7:0]             st_lsb, sp_lsb, raw_in, raw_out;
    vdms_pkg::vdms_detect_s det;
    vdms_pkg::vdms_timing_s tim;
    int                     mismatches, checked, steps;
    wire                    sda;

    assign sda = ~(sda_low | (sda_oe & ~sda_o));

    vdms_regs DUT (
        .mclk_i(mclk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .detect_i(det),
        .timing_i(tim), .gate_start_lsb_i(st_lsb),
        .gate_stop_lsb_i(sp_lsb), .raw_data_i(raw_in),
        .raw_valid_i(raw_v), .line_clock_oe_o(lclk_oe),
        .half_line_clock_oe_o(hclk_oe), .search_loop_latency_o(lat),
        .search_step_o(step), .vertical_gate_o(gate),
        .field_identifier_o(field_identifier), .raw_data_o(raw_out),
        .raw_valid_o(raw_vo)
    );
    vdms_host host (.clk_i(mclk), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(negedge mclk) if (step === 1'b1) steps++;

    task automatic stop_test();
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // One byte, acknowledge expected
    task automatic sb(input logic [7:0] b);
        logic [8:0] rx;
        host.xfer({b, 1'b1}, rx);
        cmp({7'h00, rx[0]}, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.start();
        sb(8'h42);
        sb(a);
        sb(d);
        host.stop();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] rx;
        host.start();
        sb(8'h42);
        sb(a);
        host.start();
        sb(8'h43);
        host.xfer(9'h1FF, rx);
        host.stop();
        cmp(rx[8:1], e);
    endtask

    task automatic t_reset();
        rdc(vdms_pkg::ADDR_MISC, 8'h18);
        rdc(vdms_pkg::ADDR_GAIN, 8'h80);
        rdc(vdms_pkg::ADDR_OFFSET, 8'h80);
        cmp({3'h0, lclk_oe, hclk_oe, lat}, 8'h1B);
    endtask
    task automatic t_misc();
        logic [7:0] v [4] = '{8'hC0, 8'h48, 8'hB8, 8'h00};
        logic [2:0] f;
        for (int i = 0; i < 4; i++)
        begin
            f = v[i][5:3];
            wr(vdms_pkg::ADDR_MISC, v[i]);
            rdc(vdms_pkg::ADDR_MISC, v[i]);
            cmp({6'h00, lclk_oe, hclk_oe}, {6'h00, ~v[i][7:6]});
            cmp({5'h00, lat}, {5'h00, f == 3'h0 ? 3'h3 : f});
        end
    endtask
    task automatic t_status();
        wr(vdms_pkg::ADDR_STAT1, 8'hFF);
        wr(vdms_pkg::ADDR_STAT2, 8'hFF);
        for (int i = 0; i < 8; i++)
        begin
            det = {i[0], i[1], ~i[2], i[0], ~i[0], i[1], ~i[1], i[1:0],
                   i[0], i[1], ~i[0], i[2], i[1]};
            rdc(vdms_pkg::ADDR_STAT1,
                {1'b0, ~i[0], i[0], ~i[0], i[1], ~i[1], i[1:0]});
            rdc(vdms_pkg::ADDR_STAT2,
                {i[0], ~(i[0] & i[1]), i[1], 1'b0, ~i[0], i[2], i[1],
                 ~i[2] & i[0] & i[1]});
        end
    endtask
    task automatic t_search();
        logic [7:0] m [3] = '{8'h10, 8'h08, 8'h38};
        int         n [3] = '{4, 3, 7};
        int         e [3] = '{2, 3, 1};
        for (int i = 0; i < 3; i++)
        begin
            wr(vdms_pkg::ADDR_MISC, m[i]);
            steps = 0;
            repeat (n[i])
            begin
                tim.field_start = 1'b1;
                cyc(1);
                tim.field_start = 1'b0;
                cyc(4);
            end
            cmp(8'(steps), 8'(e[i]));
        end
    endtask
    task automatic t_gate();
        logic [7:0] m [3] = '{8'h18, 8'h1C, 8'h19};
        int         lo [3] = '{10, 9, 0};
        int         hi [3] = '{20, 19, 0};
        logic       f0;
        st_lsb = 8'h0A;
        sp_lsb = 8'h14;
        for (int p = 0; p < 3; p++)
        begin
            wr(vdms_pkg::ADDR_MISC, m[p]);
            tim.field_two = m[p][2];
            f0 = field_identifier;
            for (int n = 0; n < 25; n++)
            begin
                tim.line_count = 9'(n);
                tim.line_start = 1'b1;
                cyc(1);
                tim.line_start = 1'b0;
                cyc(2);
                cmp(8'(gate), 8'(n>=lo[p] && n<hi[p]));
            end
            cmp({7'h00, field_identifier ^ f0}, 8'(p < 2));
        end
    endtask
    task automatic t_raw();
        logic [7:0] g [6] = '{8'h80, 8'hFF, 8'h80, 8'h80, 8'hFF, 8'h00};
        logic [7:0] o [6] = '{8'h80, 8'h80, 8'h00, 8'hFF, 8'hFF, 8'h80};
        logic [7:0] x [6] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'hFF, 8'h40};
        logic [7:0] e [6] = '{8'h40, 8'h7F, 8'h00, 8'hC0, 8'hFF, 8'h00};
        for (int i = 0; i < 6; i++)
        begin
            wr(vdms_pkg::ADDR_GAIN, g[i]);
            wr(vdms_pkg::ADDR_OFFSET, o[i]);
            raw_in = x[i];
            raw_v = 1'b1;
            cyc(1);
            raw_v = 1'b0;
            cmp(raw_out, e[i]);
            cmp({7'h00, raw_vo}, 8'(g[i] != 8'h00));
        end
    endtask

    initial
    begin
        rst_n = 1'b0;
        det = '0;
        tim = '0;
        st_lsb = 8'h00;
        sp_lsb = 8'h00;
        raw_in = 8'h00;
        raw_v = 1'b0;
        cyc(12);
        rst_n = 1'b1;
        cyc(10);
        t_reset();
        t_misc();
        t_status();
        t_search();
        t_gate();
        t_raw();
        stop_test();
    end
    initial
    begin
        repeat (80000) @(posedge mclk);
        mismatches++;
        stop_test();
    end
endmodule
